// File: hw/cmb_mailbox_ctrl.sv
// Mailbox transmit, abort, retry, producer/consumer and timing-mode control.
// Assumes a protocol engine on the same clock that takes the offered mailbox and
// reports start, done and lost with the mailbox index, plus matched receptions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Transmit mode raises ready until first request
// - Frame sent only after software transfer request
// - Ready stays low until sent or aborted
// - Ready mailbox interrupt, gated by mask bit
// - Remote request bit sends a remote frame
// - Smallest priority value is offered first
// - Equal priority: lower mailbox index first
// - Global transfer bits act as mailbox requests
// - Control or global abort bit aborts transmission
// - Late abort completes; early abort flags aborted
// - Lost arbitration retries automatically while pending
// - Retry disable aborts after first failed attempt
// - Producer sends only after matching remote frame
// - Remote frame while producer ready sets ignored
// - Triggered producer behaves like transmit mailbox
// - Consumer request transmits a remote frame
// - Consumer keeps first answer, flags later ones
// - Consumer ignores the remote request bit
// - Time trigger bit selects timing mode
// - Send or receive copies capture into status
// - Time window gates transmission, no retries
// - Capture at frame start or end
// - Mailbox timestamp fields read zero in triggered mode
module cmb_mailbox_ctrl #(
  parameter int NUM_MB = cmb_pkg::NUM_MB,
  parameter int IDX_W = cmb_pkg::IDX_W
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [cmb_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Offer to the protocol engine
  output logic tx_valid_out,
  output logic [IDX_W-1:0] tx_mb_out,
  output logic tx_remote_out,
  output logic [cmb_pkg::DLC_W-1:0] tx_dlc_out,
  output logic [63:0] tx_data_out,
  // Transmit events from the engine
  input wire logic [IDX_W-1:0] eng_mb_in,
  input wire logic eng_start_in,
  input wire logic eng_done_in,
  input wire logic eng_lost_in,
  // Matched receptions from the engine
  input wire logic [IDX_W-1:0] rx_mb_in,
  input wire logic rx_valid_in,
  input wire logic rx_remote_in,
  input wire logic [cmb_pkg::DLC_W-1:0] rx_dlc_in,
  input wire logic [63:0] rx_data_in,
  // Frame marks
  input wire logic sof_in,
  input wire logic eof_in,
  // Mailbox interrupt
  output logic mb_irq_out
);
  logic [cmb_pkg::MR_W-1:0] mode_r;
  logic [NUM_MB-1:0] mask_r, ready_r, pend_r, active_r, late_r, abt_r, mmi_r;
  logic [NUM_MB-1:0] armed_r, window_r, rtr_r;
  logic [cmb_pkg::PRIO_W-1:0] prio_r [NUM_MB];
  logic [cmb_pkg::DLC_W-1:0] dlc_r [NUM_MB];
  logic [cmb_pkg::TIM_W-1:0] mark_r [NUM_MB];
  logic [cmb_pkg::TIM_W-1:0] stamp_r [NUM_MB];
  logic [31:0] dlo_r [NUM_MB];
  logic [31:0] dhi_r [NUM_MB];
  cmb_pkg::cmb_mot_type mot_r [NUM_MB];
  logic [NUM_MB-1:0] mode_wr, ctrl_wr, dlo_wr, dhi_wr, stat_rd, xfer, abort;
  logic [NUM_MB-1:0] ev_start, ev_done, ev_lost, ev_rx, eligible, set_mmi;
  logic [NUM_MB*cmb_pkg::PRIO_W-1:0] prio_flat;
  logic [cmb_pkg::TIM_W-1:0] tim, tstamp;
  logic [IDX_W-1:0] mb_idx, sel_idx;
  logic [4:0] mb_sub;
  logic mb_hit, glb_xfer, glb_abort, sel_valid, tt_sync, time_trigger_select, retry_disable;

  // Address decode
  assign mb_idx = reg_addr_in[cmb_pkg::MB_IDX_LSB +: IDX_W];
  assign mb_sub = reg_addr_in[4:0];
  assign mb_hit = reg_addr_in[cmb_pkg::MB_WIN_BIT] && (int'(mb_idx) < NUM_MB);
  assign glb_xfer = reg_wr_in && reg_addr_in == cmb_pkg::OFS_GXFER;
  assign glb_abort = reg_wr_in && reg_addr_in == cmb_pkg::OFS_GABORT;
  assign time_trigger_select = mode_r[cmb_pkg::MR_TTM];
  assign retry_disable = mode_r[cmb_pkg::MR_RETRY_DISABLE];
  // New basic cycle: reference frame into the last mailbox
  assign tt_sync = time_trigger_select && ev_rx[NUM_MB-1] && !rx_remote_in;

  // Default clocking for the checks in this module
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  for (genvar i = 0; i < NUM_MB; i++) begin : g_mb
    logic sel;
    logic is_tx, is_prod, is_cons;
    assign sel = mb_hit && (mb_idx == IDX_W'(i));
    assign is_tx = mot_r[i] == cmb_pkg::MOT_TX;
    assign is_prod = mot_r[i] == cmb_pkg::MOT_PRODUCER;
    assign is_cons = mot_r[i] == cmb_pkg::MOT_CONSUMER;
    // Per-mailbox strobes and engine events
    assign mode_wr[i] = reg_wr_in && sel && mb_sub == cmb_pkg::MB_MODE;
    assign ctrl_wr[i] = reg_wr_in && sel && mb_sub == cmb_pkg::MB_CTRL;
    assign dlo_wr[i] = reg_wr_in && sel && mb_sub == cmb_pkg::MB_DLO;
    assign dhi_wr[i] = reg_wr_in && sel && mb_sub == cmb_pkg::MB_DHI;
    assign stat_rd[i] = reg_rd_in && sel && mb_sub == cmb_pkg::MB_STAT;
    assign xfer[i] = (ctrl_wr[i] && reg_wdata_in[cmb_pkg::MCR_XFER]) ||
                     (glb_xfer && reg_wdata_in[i]);
    assign abort[i] = (ctrl_wr[i] && reg_wdata_in[cmb_pkg::MCR_ABORT]) ||
                      (glb_abort && reg_wdata_in[i]);
    assign ev_start[i] = eng_start_in && eng_mb_in == IDX_W'(i);
    assign ev_done[i] = eng_done_in && eng_mb_in == IDX_W'(i) && active_r[i];
    assign ev_lost[i] = eng_lost_in && eng_mb_in == IDX_W'(i) && active_r[i];
    assign ev_rx[i] = rx_valid_in && rx_mb_in == IDX_W'(i);
    // In triggered mode a pending mailbox contends only inside its window
    assign eligible[i] = pend_r[i] && (!time_trigger_select || window_r[i]);
    assign prio_flat[i*cmb_pkg::PRIO_W +: cmb_pkg::PRIO_W] = prio_r[i];
    // Frame dropped because ready data is still held
    assign set_mmi[i] = ev_rx[i] && ready_r[i] &&
                        ((is_prod && rx_remote_in) || (is_cons && !rx_remote_in));

    // Transfer flow; transmit events outrank transfer and abort requests, receptions rank below them, and a mode write outranks them all
    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        ready_r[i] <= 1'b0;
        pend_r[i] <= 1'b0;
        active_r[i] <= 1'b0;
        late_r[i] <= 1'b0;
        abt_r[i] <= 1'b0;
        armed_r[i] <= 1'b0;
      end else if (mode_wr[i]) begin
        ready_r[i] <= reg_wdata_in[cmb_pkg::MMR_MOT_LSB +: cmb_pkg::MOT_W] ==
                      cmb_pkg::MOT_TX ||
                      reg_wdata_in[cmb_pkg::MMR_MOT_LSB +: cmb_pkg::MOT_W] ==
                      cmb_pkg::MOT_PRODUCER;
        pend_r[i] <= 1'b0;
        active_r[i] <= 1'b0;
        late_r[i] <= 1'b0;
        abt_r[i] <= 1'b0;
        armed_r[i] <= 1'b0;
      end else if (ev_done[i]) begin
        active_r[i] <= 1'b0;
        pend_r[i] <= 1'b0;
        late_r[i] <= 1'b0;
        armed_r[i] <= is_cons;
        ready_r[i] <= !is_cons;
      end else if (ev_lost[i]) begin
        active_r[i] <= 1'b0;
        // Stays pending for the next arbitration unless retry is off or a late abort is waiting
        if (retry_disable || late_r[i]) begin
          pend_r[i] <= 1'b0;
          late_r[i] <= 1'b0;
          ready_r[i] <= 1'b1;
          abt_r[i] <= 1'b1;
        end
      end else if (ev_start[i] && pend_r[i]) begin
        active_r[i] <= 1'b1;
      end else if (abort[i] && active_r[i]) begin
        late_r[i] <= 1'b1;
      end else if (abort[i] && (pend_r[i] || (is_prod && armed_r[i]))) begin
        pend_r[i] <= 1'b0;
        armed_r[i] <= 1'b0;
        ready_r[i] <= 1'b1;
        abt_r[i] <= 1'b1;
      end else if (xfer[i] && (is_tx || is_prod || is_cons) && !pend_r[i]) begin
        ready_r[i] <= 1'b0;
        abt_r[i] <= 1'b0;
        armed_r[i] <= is_prod;
        pend_r[i] <= !is_prod;
      end else if (ev_rx[i] && is_prod && rx_remote_in && armed_r[i]) begin
        armed_r[i] <= 1'b0;
        pend_r[i] <= 1'b1;
      end else if (ev_rx[i] && is_cons && !rx_remote_in && armed_r[i]) begin
        armed_r[i] <= 1'b0;
        ready_r[i] <= 1'b1;
      end
    end

    // Ignored-frame flag; a new drop beats the clearing status read
    always_ff @(posedge core_clk_in) begin
      if (rst_in || mode_wr[i]) begin
        mmi_r[i] <= 1'b0;
      end else if (set_mmi[i]) begin
        mmi_r[i] <= 1'b1;
      end else if (stat_rd[i]) begin
        mmi_r[i] <= 1'b0;
      end
    end

    // Time window opens at the mark, shuts on any attempt
    always_ff @(posedge core_clk_in) begin
      if (rst_in || mode_wr[i] || tt_sync) begin
        window_r[i] <= 1'b0;
      end else if (ev_lost[i] || ev_done[i]) begin
        window_r[i] <= 1'b0;
      end else if (tim == mark_r[i]) begin
        window_r[i] <= 1'b1;
      end
    end

    // Mode fields
    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        mot_r[i] <= cmb_pkg::MOT_DISABLED;
        prio_r[i] <= '0;
        mark_r[i] <= '0;
      end else if (mode_wr[i]) begin
        mot_r[i] <= cmb_pkg::cmb_mot_type'(
                    reg_wdata_in[cmb_pkg::MMR_MOT_LSB +: cmb_pkg::MOT_W]);
        prio_r[i] <= reg_wdata_in[cmb_pkg::MMR_PRIO_LSB +: cmb_pkg::PRIO_W];
        mark_r[i] <= reg_wdata_in[cmb_pkg::MMR_MARK_LSB +: cmb_pkg::TIM_W];
      end
    end

    // Data, length and remote bit; a consumer answer overwrites data and length
    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        dlo_r[i] <= '0;
        dhi_r[i] <= '0;
        dlc_r[i] <= '0;
        rtr_r[i] <= 1'b0;
      end else if (ev_rx[i] && is_cons && !rx_remote_in && armed_r[i]) begin
        dlo_r[i] <= rx_data_in[31:0];
        dhi_r[i] <= rx_data_in[63:32];
        dlc_r[i] <= rx_dlc_in;
      end else begin
        if (dlo_wr[i]) begin
          dlo_r[i] <= reg_wdata_in;
        end
        if (dhi_wr[i]) begin
          dhi_r[i] <= reg_wdata_in;
        end
        if (ctrl_wr[i] && reg_wdata_in[cmb_pkg::MCR_XFER]) begin
          dlc_r[i] <= reg_wdata_in[cmb_pkg::MCR_DLC_LSB +: cmb_pkg::DLC_W];
          rtr_r[i] <= reg_wdata_in[cmb_pkg::MCR_RTR];
        end
      end
    end

    // Timestamp of the last frame sent or stored by this mailbox
    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        stamp_r[i] <= '0;
      end else if (ev_done[i] || (ev_rx[i] && is_cons && !rx_remote_in && armed_r[i])) begin
        stamp_r[i] <= tstamp;
      end
    end

    // Checks per mailbox
    a_tx_ready_on: assert property (mode_wr[i] && reg_wdata_in[26:24] == 3'h3 |=> ready_r[i])
      else $error("transmit mode did not raise ready");
    a_xfer_drops: assert property (xfer[i] && is_tx && !pend_r[i] && !mode_wr[i] &&
                                   !ev_done[i] && !ev_lost[i] && !abort[i]
                                   |=> !ready_r[i] && pend_r[i])
      else $error("transfer request did not clear ready");
    a_cons_mode_off: assert property (mode_wr[i] && reg_wdata_in[26:24] == 3'h4
                                      |=> !ready_r[i] ##1 !ready_r[i] || xfer[i])
      else $error("consumer mode raised ready");
    a_early_abort: assert property (abort[i] && pend_r[i] && !active_r[i] && !mode_wr[i] &&
                                    !ev_start[i] |=> ready_r[i] && abt_r[i] && !pend_r[i])
      else $error("early abort not flagged");
    a_retry_disable_abort: assert property (ev_lost[i] && retry_disable && !mode_wr[i]
                                   |=> abt_r[i] && ready_r[i] && !pend_r[i])
      else $error("lost frame not aborted with retry disabled");
    a_prod_ignore: assert property (set_mmi[i] && !mode_wr[i] |=> mmi_r[i])
      else $error("ignored frame not flagged");
    a_tt_gate: assert property (time_trigger_select && ev_lost[i] |=> !eligible[i])
      else $error("mailbox retried inside its window");
    a_prio_best: assert property (sel_valid && eligible[i] |-> prio_r[i] >= prio_r[sel_idx])
      else $error("worse priority selected");
    a_tie_low: assert property (sel_valid && eligible[i] && prio_r[i] == prio_r[sel_idx]
                                |-> IDX_W'(i) >= sel_idx)
      else $error("tie not given to lower index");
  end

  // Priority pick among contending mailboxes
  cmb_prio_arb #(
    .N(NUM_MB),
    .IDX_W(IDX_W),
    .PRIO_W(cmb_pkg::PRIO_W)
  ) u_arb (
    .req_in(eligible),
    .prio_in(prio_flat),
    .valid_out(sel_valid),
    .idx_out(sel_idx)
  );

  // Timer and frame capture
  cmb_timebase #(
    .TIM_W(cmb_pkg::TIM_W)
  ) u_time (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .sync_clr_in(tt_sync),
    .freeze_en_in(mode_r[cmb_pkg::MR_TIMFRZ]),
    .at_eof_in(mode_r[cmb_pkg::MR_CAPTURE_AT_FRAME_END]),
    .sof_in(sof_in),
    .eof_in(eof_in),
    .count_out(tim),
    .capture_out(tstamp)
  );

  // Controller mode and interrupt mask
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mode_r <= cmb_pkg::MR_RESET;
      mask_r <= '0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == cmb_pkg::OFS_MODE) begin
        mode_r <= reg_wdata_in[cmb_pkg::MR_W-1:0];
      end
      if (reg_addr_in == cmb_pkg::OFS_IEN) begin
        mask_r <= mask_r | reg_wdata_in[NUM_MB-1:0];
      end
      if (reg_addr_in == cmb_pkg::OFS_IDIS) begin
        mask_r <= mask_r & ~reg_wdata_in[NUM_MB-1:0];
      end
    end
  end

  // Registered offer; a disabled controller offers nothing
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_valid_out <= 1'b0;
      tx_mb_out <= '0;
      tx_remote_out <= 1'b0;
      tx_dlc_out <= '0;
      tx_data_out <= '0;
    end else begin
      tx_valid_out <= sel_valid && mode_r[cmb_pkg::MR_CANEN];
      tx_mb_out <= sel_idx;
      // A consumer always sends a remote frame whatever its bit says
      tx_remote_out <= (mot_r[sel_idx] == cmb_pkg::MOT_CONSUMER) ? 1'b1 : rtr_r[sel_idx];
      tx_dlc_out <= dlc_r[sel_idx];
      tx_data_out <= {dhi_r[sel_idx], dlo_r[sel_idx]};
    end
  end

  // Interrupt while any unmasked mailbox holds ready
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mb_irq_out <= 1'b0;
    end else begin
      mb_irq_out <= |(ready_r & mask_r);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !reg_rd_in) begin
      reg_rdata_out <= '0;
    end else if (mb_hit) begin
      case (mb_sub)
        cmb_pkg::MB_MODE: reg_rdata_out <= {5'h00, mot_r[mb_idx], 4'h0, prio_r[mb_idx],
                                            mark_r[mb_idx]};
        cmb_pkg::MB_STAT: reg_rdata_out <= {7'h00, mmi_r[mb_idx], ready_r[mb_idx],
                                            abt_r[mb_idx], 1'b0, rtr_r[mb_idx], dlc_r[mb_idx],
                                            time_trigger_select ? 16'h0000 : stamp_r[mb_idx]};
        cmb_pkg::MB_DLO: reg_rdata_out <= dlo_r[mb_idx];
        cmb_pkg::MB_DHI: reg_rdata_out <= dhi_r[mb_idx];
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      case (reg_addr_in)
        cmb_pkg::OFS_MODE: reg_rdata_out <= 32'(mode_r);
        cmb_pkg::OFS_IMASK: reg_rdata_out <= 32'(mask_r);
        cmb_pkg::OFS_STATUS: reg_rdata_out <= 32'(ready_r);
        cmb_pkg::OFS_TIMER: reg_rdata_out <= 32'(tim);
        cmb_pkg::OFS_TSTAMP: reg_rdata_out <= 32'(tstamp);
        default: reg_rdata_out <= '0;
      endcase
    end
  end

  // Global checks
  a_irq_gate: assert property (##1 mb_irq_out == $past(|(ready_r & mask_r)))
    else $error("interrupt does not follow masked ready");
  a_tt_stamp: assert property (reg_rd_in && time_trigger_select && mb_hit && mb_sub == 5'h10
                               |=> reg_rdata_out[15:0] == 16'h0000)
    else $error("timestamp visible in triggered mode");
  c_retry: cover property (ev_lost[1] && !retry_disable ##[1:20] tx_valid_out);
  c_late_abort: cover property (abort[1] && active_r[1] ##[1:40] ev_done[1]);
  c_producer: cover property (ev_rx[3] && rx_remote_in && armed_r[3] ##[1:40] abt_r[3]);
  c_consumer: cover property (ev_done[2] && mot_r[2] == cmb_pkg::MOT_CONSUMER
                              ##[1:60] ready_r[2]);
endmodule
`default_nettype wire

// File: hw/cmb_prio_arb.sv
// Picks the pending mailbox with the smallest priority value, lowest index on a tie.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module cmb_prio_arb #(
  parameter int N = cmb_pkg::NUM_MB,
  parameter int IDX_W = cmb_pkg::IDX_W,
  parameter int PRIO_W = cmb_pkg::PRIO_W
) (
  // Candidates
  input wire logic [N-1:0] req_in,
  input wire logic [N*PRIO_W-1:0] prio_in,
  // Winner
  output logic valid_out,
  output logic [IDX_W-1:0] idx_out
);
  logic [PRIO_W-1:0] best_p;

  // Walk from the top index down so a tie falls to the lower index
  always_comb begin
    valid_out = 1'b0;
    idx_out = '0;
    best_p = '1;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i] && (!valid_out || prio_in[i*PRIO_W +: PRIO_W] <= best_p)) begin
        valid_out = 1'b1;
        idx_out = IDX_W'(i);
        best_p = prio_in[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/cmb_timebase.sv
// Free-running internal timer with freeze and frame-edge capture register.
// Frame marks come from the protocol engine on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cmb_timebase #(
  parameter int TIM_W = cmb_pkg::TIM_W
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic sync_clr_in,
  input wire logic freeze_en_in,
  input wire logic at_eof_in,
  // Frame marks
  input wire logic sof_in,
  input wire logic eof_in,
  // Values
  output logic [TIM_W-1:0] count_out,
  output logic [TIM_W-1:0] capture_out
);
  // Counter; with freeze it parks at all ones to avoid a silent roll-over
  always_ff @(posedge core_clk_in) begin
    if (rst_in || sync_clr_in) begin
      count_out <= '0;
    end else if (!(freeze_en_in && count_out == '1)) begin
      count_out <= count_out + 1'b1;
    end
  end

  // Capture at start or end of frame
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      capture_out <= '0;
    end else if (at_eof_in ? eof_in : sof_in) begin
      capture_out <= count_out;
    end
  end
endmodule
`default_nettype wire

// File: include/cmb_pkg.sv
// Shared constants and types for the CAN mailbox transmit, remote and timing logic.
// Assumes a 32-bit register port with byte addresses and 16 mailboxes of 0x20 bytes each.
package cmb_pkg;
  // Sizes
  localparam int NUM_MB = 16;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 10;
  localparam int TIM_W = 16;
  localparam int PRIO_W = 4;
  localparam int DLC_W = 4;
  localparam int MOT_W = 3;

  // Global register offsets
  localparam logic [9:0] OFS_MODE = 10'h000;
  localparam logic [9:0] OFS_IEN = 10'h004;
  localparam logic [9:0] OFS_IDIS = 10'h008;
  localparam logic [9:0] OFS_IMASK = 10'h00c;
  localparam logic [9:0] OFS_STATUS = 10'h010;
  localparam logic [9:0] OFS_TIMER = 10'h018;
  localparam logic [9:0] OFS_TSTAMP = 10'h01c;
  localparam logic [9:0] OFS_GXFER = 10'h024;
  localparam logic [9:0] OFS_GABORT = 10'h028;

  // Mailbox window: bit 9 selects it, bits 8:5 the mailbox, bits 4:0 the register
  localparam int MB_WIN_BIT = 9;
  localparam int MB_IDX_LSB = 5;
  localparam logic [4:0] MB_MODE = 5'h00;
  localparam logic [4:0] MB_STAT = 5'h10;
  localparam logic [4:0] MB_DLO = 5'h14;
  localparam logic [4:0] MB_DHI = 5'h18;
  localparam logic [4:0] MB_CTRL = 5'h1c;

  // Controller mode register fields
  localparam int MR_W = 8;
  localparam logic [7:0] MR_RESET = 8'h00;
  localparam int MR_CANEN = 0;
  localparam int MR_CAPTURE_AT_FRAME_END = 4;
  localparam int MR_TTM = 5;
  localparam int MR_TIMFRZ = 6;
  localparam int MR_RETRY_DISABLE = 7;

  // Mailbox mode register fields
  localparam int MMR_MARK_LSB = 0;
  localparam int MMR_PRIO_LSB = 16;
  localparam int MMR_MOT_LSB = 24;

  // Mailbox control register fields
  localparam int MCR_DLC_LSB = 16;
  localparam int MCR_RTR = 20;
  localparam int MCR_ABORT = 22;
  localparam int MCR_XFER = 23;

  // Mailbox object type, codes 0 to 5 in this order
  typedef enum logic [MOT_W-1:0] {
    MOT_DISABLED, MOT_RX, MOT_RX_OVR, MOT_TX, MOT_CONSUMER, MOT_PRODUCER
  } cmb_mot_type;
endpackage

// File: sim/cmb_eng_model.sv
// Protocol engine stand-in: starts the offered mailbox when told to.
// Assumes the mailbox control clock; each start ends in done or lost.
`timescale 1ns/1ps
`default_nettype none
module cmb_eng_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Offer and command
  input wire logic tx_valid_in,
  input wire logic [3:0] tx_mb_in,
  input wire logic go_in,
  input wire logic lose_in,
  // Events
  output logic [3:0] eng_mb_out,
  output logic eng_start_out,
  output logic eng_done_out,
  output logic eng_lost_out
);
  logic [2:0] cnt_r;
  logic lose_r;
  // Start pulse, outcome four cycles on; offer is latched at start
  always_ff @(posedge core_clk_in) begin
    eng_start_out <= 1'b0;
    eng_done_out <= 1'b0;
    eng_lost_out <= 1'b0;
    if (rst_in) begin
      cnt_r <= 3'h0;
      eng_mb_out <= 4'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
      if (cnt_r == 3'h1) begin
        eng_done_out <= !lose_r;
        eng_lost_out <= lose_r;
      end
    end else if (go_in && tx_valid_in) begin
      eng_mb_out <= tx_mb_in;
      lose_r <= lose_in;
      eng_start_out <= 1'b1;
      cnt_r <= 3'h4;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the mailbox control with an engine model.
// Assumes 200 MHz clock; frame marks come from the bench.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] addr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0, rd_s = 1'b0, go = 1'b0, lose = 1'b0, rxv = 1'b0, rxr = 1'b0;
  logic [3:0] rxmb = 4'h0, emb, txmb, txdlc;
  logic [31:0] rdata, d;
  logic [63:0] txd;
  logic txv, txr, st, dn, ls, irq;
  logic sof = 1'b0, eof = 1'b0;
  logic [15:0] cap;
  int miscompares = 0, samples_checked = 0;
  int rows [4][5] = '{'{3, 5, 9, 2, 9}, '{2, 7, 6, 7, 2}, '{0, 15, 12, 0, 12}, '{4, 0, 1, 0, 1}};
  cmb_mailbox_ctrl u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .tx_valid_out(txv), .tx_mb_out(txmb), .tx_remote_out(txr), .tx_dlc_out(txdlc),
    .tx_data_out(txd), .eng_mb_in(emb), .eng_start_in(st), .eng_done_in(dn),
    .eng_lost_in(ls), .rx_mb_in(rxmb), .rx_valid_in(rxv), .rx_remote_in(rxr),
    .rx_dlc_in(4'h8), .rx_data_in(64'h0123_4567_89ab_cdef), .sof_in(sof), .eof_in(eof),
    .mb_irq_out(irq));
  cmb_eng_model u_eng (.core_clk_in(core_clk_in), .rst_in(rst_in), .tx_valid_in(txv),
    .tx_mb_in(txmb), .go_in(go), .lose_in(lose), .eng_mb_out(emb), .eng_start_out(st),
    .eng_done_out(dn), .eng_lost_out(ls));
  // Clock
  initial begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  function automatic logic [9:0] mb(input int n, input logic [4:0] o);
    return {1'b1, 4'(n), o};
  endfunction
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge core_clk_in);
    wr_s <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdr(input logic [9:0] a);
    @(posedge core_clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge core_clk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rx(input int n, input logic r);
    @(posedge core_clk_in);
    rxmb <= 4'(n);
    rxr <= r;
    rxv <= 1'b1;
    @(posedge core_clk_in);
    rxv <= 1'b0;
  endtask
  task automatic send(input logic l);
    @(posedge core_clk_in);
    go <= 1'b1;
    lose <= l;
    @(posedge core_clk_in);
    go <= 1'b0;
    repeat (8) @(posedge core_clk_in);
  endtask
  task automatic end_of_test();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog, well past the expected run length
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdr(10'h000); `CHK(d, 32'h0)
    rdr(10'h100); `CHK(d, 32'h0)
    wr(10'h000, 32'h1);
    // Priority rows: two mailboxes raced through the global bits
    for (int i = 0; i < 4; i++) begin
      wr(mb(rows[i][0], 5'h0), {8'h03, 4'h0, 4'(rows[i][1]), 16'h0});
      wr(mb(rows[i][2], 5'h0), {8'h03, 4'h0, 4'(rows[i][3]), 16'h0});
      rdr(mb(rows[i][0], 5'h10)); `CHK(d[23], 1'b1)
      wr(10'h024, (32'h1 << rows[i][0]) | (32'h1 << rows[i][2]));
      repeat (3) @(posedge core_clk_in);
      `CHK({txv, txmb}, {1'b1, 4'(rows[i][4])})
      wr(10'h028, (32'h1 << rows[i][0]) | (32'h1 << rows[i][2]));
      rdr(mb(rows[i][0], 5'h10)); `CHK(d[24:22], 3'b011)
    end
    // Interrupt mask, send with a late abort
    wr(mb(1, 5'h0), 32'h0300_0000);
    wr(10'h004, 32'h2);
    repeat (2) @(posedge core_clk_in);
    `CHK(irq, 1'b1)
    wr(10'h008, 32'h2);
    repeat (2) @(posedge core_clk_in);
    `CHK(irq, 1'b0)
    wr(10'h004, 32'h2);
    wr(mb(1, 5'h14), 32'h1234_5678);
    wr(mb(1, 5'h18), 32'h9abc_def0);
    wr(mb(1, 5'h1c), 32'h0088_0000);
    rdr(mb(1, 5'h10)); `CHK(d[23], 1'b0)
    `CHK(irq, 1'b0)
    `CHK({txv, txr, txdlc, txd}, {2'b10, 4'h8, 64'h9abc_def0_1234_5678})
    @(posedge core_clk_in);
    go <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
    wr(mb(1, 5'h1c), 32'h0040_0000);
    repeat (6) @(posedge core_clk_in);
    rdr(mb(1, 5'h10)); `CHK(d[23:22], 2'b10)
    // Lost arbitration with and without retry
    wr(mb(1, 5'h1c), 32'h0080_0000);
    send(1'b1);
    rdr(mb(1, 5'h10)); `CHK({d[23], txv, txmb}, 6'h11)
    wr(10'h000, 32'h81);
    send(1'b1);
    rdr(mb(1, 5'h10)); `CHK(d[23:22], 2'b11)
    wr(10'h000, 32'h1);
    // Consumer: remote frame out, first answer kept
    wr(mb(6, 5'h0), 32'h0200_0000);
    wr(mb(2, 5'h0), 32'h0400_0000);
    rdr(mb(2, 5'h10)); `CHK(d[23], 1'b0)
    wr(mb(2, 5'h1c), 32'h0080_0000);
    repeat (3) @(posedge core_clk_in);
    `CHK({txv, txmb, txr}, 6'h25)
    // Start mark lands two edges after this timer read; the end mark must not capture
    rdr(10'h018);
    cap = d[15:0] + 16'h2;
    @(posedge core_clk_in);
    sof <= 1'b1;
    @(posedge core_clk_in);
    sof <= 1'b0;
    eof <= 1'b1;
    @(posedge core_clk_in);
    eof <= 1'b0;
    send(1'b0);
    rx(2, 1'b0);
    rdr(10'h01c); `CHK(d[15:0], cap)
    rdr(mb(2, 5'h10)); `CHK(d[24:23], 2'b01)
    `CHK(d[15:0], cap)
    rdr(mb(2, 5'h14)); `CHK(d, 32'h89ab_cdef)
    rx(2, 1'b0);
    rdr(mb(2, 5'h10)); `CHK(d[24], 1'b1)
    rdr(mb(2, 5'h10)); `CHK(d[24], 1'b0)
    // Producer: ignored remote, then armed and triggered
    wr(mb(3, 5'h0), 32'h0500_0000);
    rx(3, 1'b1);
    rdr(mb(3, 5'h10)); `CHK(d[24:23], 2'b11)
    rdr(mb(3, 5'h10)); `CHK(d[24], 1'b0)
    wr(mb(3, 5'h1c), 32'h0080_0000);
    repeat (3) @(posedge core_clk_in);
    `CHK(txv, 1'b0)
    rx(3, 1'b1);
    repeat (3) @(posedge core_clk_in);
    `CHK({txv, txmb}, 5'h13)
    wr(mb(3, 5'h1c), 32'h0040_0000);
    rdr(mb(3, 5'h10)); `CHK(d[23:22], 2'b11)
    // Time trigger mode hides the mailbox stamps
    wr(10'h000, 32'h21);
    // Window at mark 0x40, counted from the reference frame that clears the timer
    wr(mb(1, 5'h0), 32'h0300_0040);
    wr(mb(1, 5'h1c), 32'h0080_0000);
    rx(15, 1'b0);
    repeat (3) @(posedge core_clk_in);
    `CHK(txv, 1'b0)
    repeat (80) @(posedge core_clk_in);
    `CHK({txv, txmb}, 5'h11)
    rdr(mb(2, 5'h10)); `CHK(d[15:0], 16'h0)
    end_of_test();
  end
endmodule
`default_nettype wire
